// ### lrc_defs.svh
`ifndef LRC_DEFS_SVH
`define LRC_DEFS_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define LRC_ADDR_W        16
`define LRC_OFF_LINK_CTL  16'h0550
`define LRC_OFF_REL_CTL   16'h0560
`define LRC_OFF_REL_STS   16'h0564
`define LRC_OFF_THRESH    16'h5680
`define LRC_OFF_COUNTER   16'h056C
`define LRC_OFF_INT_STS   16'h0570
`define LRC_OFF_INT_MSK   16'h0574

// ****************************************
// Field positions
// ****************************************
`define LRC_BIT_RETRAIN   5
`define LRC_BIT_EN        0
`define LRC_BIT_TYPE      1
`define LRC_BIT_ULD       0
`define LRC_THR_MSB       7
`define LRC_THR_LSB       0
`define LRC_PER_MSB       31
`define LRC_PER_LSB       8
`define LRC_INT_ULD       0
`define LRC_INT_WINDOW    1
`define LRC_INT_SAT       2

// ****************************************
// Reset values and encodings
// ****************************************
`define LRC_THRESH_RST    32'hFFFFFFFF
`define LRC_CTL_RST       2'h0
`define LRC_INT_RST       3'h0
`define LRC_ETYPE_BIT     1'b0
`define LRC_ETYPE_STATE   1'b1

// ****************************************
// Timing
// ****************************************
`define LRC_TIME_US_NS    1000
`define LRC_CLK_NS        10
`define LRC_US_CYCLES     (`LRC_TIME_US_NS / `LRC_CLK_NS)
`define LRC_PRE_W         7

`endif

// ### lrc_pkg.sv
package lrc_pkg;
   // Error tally width type
   typedef logic [7:0]  err_count_t;
   // Window elapsed width type
   typedef logic [23:0] period_count_t;
   // Interrupt vector type
   typedef logic [2:0]  int_vec_t;
endpackage

// ### sat_counter.sv
`timescale 1ns/1ps
`default_nettype none
// Saturating counter with clear, hold and restart, in that priority
module sat_counter #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   // Controls
   input  wire logic             clear,
   input  wire logic             hold,
   input  wire logic             restart,
   input  wire logic             step,
   // Count
   output logic [WIDTH-1:0]      count_reg,
   output logic                  at_max
);
   assign at_max = &count_reg;

   // Clear beats freeze, freeze beats restart, restart beats step
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count_reg <= '0;
      end else if (clear) begin
         count_reg <= '0;
      end else if (hold) begin
         count_reg <= count_reg;
      end else if (restart) begin
         count_reg <= '0;
      end else if (step && !at_max) begin
         // Saturate rather than wrap
         count_reg <= count_reg + 1'b1;
      end
   end
endmodule
`default_nettype wire

// ### us_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "lrc_defs.svh"
// One-cycle tick every microsecond of core clock
module us_prescaler (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   // Tick out
   output logic                  tick
);
   logic [`LRC_PRE_W-1:0] pre_reg;   // Cycle count within the microsecond

   assign tick = (pre_reg == `LRC_PRE_W'(`LRC_US_CYCLES - 1));

   // Free running divider, never stopped so the window stays true time
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_reg <= '0;
      end else if (tick) begin
         pre_reg <= '0;
      end else begin
         pre_reg <= pre_reg + 1'b1;
      end
   end
endmodule
`default_nettype wire

// ### link_reliability_counters.sv
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "lrc_defs.svh"
//Function
// RULE_01 - Eight-bit error tally, saturating
// RULE_02 - Retrain or detect clears error tally
// RULE_03 - Enable rising edge clears both counters
// RULE_04 - Unreliable link freezes error tally
// RULE_05 - Error tally restarts at window end
// RULE_06 - Counters run while monitoring disabled
// RULE_07 - 24-bit microsecond window counter, saturating
// RULE_08 - Retrain or detect clears window counter
// RULE_09 - Unreliable link freezes window counter
// RULE_10 - Window counter restarts at period
// RULE_11 - Both counts readable in one register
// RULE_12 - Sticky unreliable flag, write one clears
// RULE_13 - Control bit selects counted error type
// RULE_14 - Threshold and period fields, all-ones default
// RULE_15 - Prescaler makes one-microsecond tick
module link_reliability_counters (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   // APB slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [15:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   // Link events
   input  wire logic             link_bit_error,
   input  wire logic             link_state_error,
   input  wire logic             link_detect,
   // Link control and interrupt
   output logic                  link_retrain_request,
   output logic                  irq
);
   // ****************************************
   // Declarations
   // ****************************************
   logic [1:0]                 reliability_control_reg;   // Enable and error type
   logic                       en_prev_reg;               // Enable delayed one cycle
   logic                       unreliable_link_flag_reg;  // Sticky unreliable flag
   logic [31:0]                reliability_threshold_reg; // Threshold and period
   logic                       retrain_pulse_reg;         // One-cycle retrain request
   lrc_pkg::int_vec_t          int_status_reg;            // Sticky events
   lrc_pkg::int_vec_t          int_mask_reg;              // Event enables
   logic [31:0]                prdata_reg;                // Captured read data
   logic                       pslverr_reg;               // Captured decode error
   lrc_pkg::err_count_t        error_tally;               // Error count
   lrc_pkg::period_count_t     window_elapsed_us;         // Window count
   logic                       tally_max;                 // Error count saturated
   logic                       window_max;                // Window count saturated
   logic                       us_tick;                   // Microsecond tick
   logic                       enable;                    // Monitoring enabled
   logic                       en_rise;                   // Enable went zero to one
   logic                       clear_all;                 // Clear for both counters
   logic                       freeze;                    // Link judged unreliable
   logic                       window_end;                // Window reached period
   logic                       err_event;                 // Selected error pulse
   logic                       uld_set;                   // Threshold reached
   lrc_pkg::int_vec_t          int_events;                // Raw event pulses
   logic                       setup_ph;                  // APB setup cycle
   logic                       wr_en;                     // APB write commit
   logic [31:0]                rd_data;                   // Read mux
   logic                       rd_err;                    // Unmapped address
   lrc_pkg::err_count_t        thr_field;                 // Error threshold
   lrc_pkg::period_count_t     per_field;                 // Period in microseconds

   // ****************************************
   // Control decode
   // ****************************************
   assign enable    = reliability_control_reg[`LRC_BIT_EN];
   assign en_rise   = enable && !en_prev_reg;                              // RULE_03
   // Detect covers both link-down and full retrain, so one clear serves both
   assign clear_all = retrain_pulse_reg || link_detect || en_rise;       // RULE_02 RULE_08
   assign freeze    = unreliable_link_flag_reg;                           // RULE_04 RULE_09
   assign thr_field = reliability_threshold_reg[`LRC_THR_MSB:`LRC_THR_LSB];
   assign per_field = reliability_threshold_reg[`LRC_PER_MSB:`LRC_PER_LSB];
   assign window_end = (window_elapsed_us == per_field);                  // RULE_05 RULE_10
   // Only port-initiated recovery entries reach link_state_error
   assign err_event = (reliability_control_reg[`LRC_BIT_TYPE] == `LRC_ETYPE_STATE) ?
                      link_state_error : link_bit_error;                  // RULE_13
   // Zero threshold is undefined; here it simply flags at once
   assign uld_set   = enable && (error_tally >= thr_field);               // RULE_12

   // ****************************************
   // Counters
   // ****************************************
   // Microsecond time base
   us_prescaler u_pre (
      .clk    (clk),
      .arst_n (arst_n),
      .tick   (us_tick)                                                   // RULE_15
   );

   // Error tally; enable is not an input, so it counts when disabled
   sat_counter #(.WIDTH(8)) u_err (
      .clk       (clk),
      .arst_n    (arst_n),
      .clear     (clear_all),
      .hold      (freeze),
      .restart   (window_end),
      .step      (err_event),
      .count_reg (error_tally),                                           // RULE_01 RULE_06
      .at_max    (tally_max)
   );

   // Window counter, advanced by the tick only
   sat_counter #(.WIDTH(24)) u_win (
      .clk       (clk),
      .arst_n    (arst_n),
      .clear     (clear_all),
      .hold      (freeze),
      .restart   (window_end),
      .step      (us_tick),
      .count_reg (window_elapsed_us),                                     // RULE_07 RULE_06
      .at_max    (window_max)
   );

   // ****************************************
   // Monitor state
   // ****************************************
   // Enable history for edge detection
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         en_prev_reg <= 1'b0;
      end else begin
         en_prev_reg <= enable;
      end
   end

   // Sticky flag: set wins over a same-cycle write-one clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         unreliable_link_flag_reg <= 1'b0;
      end else if (uld_set) begin
         unreliable_link_flag_reg <= 1'b1;                                // RULE_12
      end else if (wr_en && paddr == `LRC_OFF_REL_STS && pwdata[`LRC_BIT_ULD]) begin
         unreliable_link_flag_reg <= 1'b0;                                // RULE_12
      end
   end

   // Retrain request pulse, self clearing so the bit reads as zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         retrain_pulse_reg <= 1'b0;
      end else begin
         retrain_pulse_reg <= wr_en && (paddr == `LRC_OFF_LINK_CTL) &&
                              pwdata[`LRC_BIT_RETRAIN];
      end
   end
   assign link_retrain_request = retrain_pulse_reg;

   // ****************************************
   // Software registers
   // ****************************************
   // Control: enable and error type
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reliability_control_reg <= `LRC_CTL_RST;
      end else if (wr_en && paddr == `LRC_OFF_REL_CTL) begin
         reliability_control_reg <= pwdata[1:0];                          // RULE_13
      end
   end

   // Threshold and period, all ones after reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reliability_threshold_reg <= `LRC_THRESH_RST;                    // RULE_14
      end else if (wr_en && paddr == `LRC_OFF_THRESH) begin
         reliability_threshold_reg <= pwdata;                             // RULE_14
      end
   end

   // ****************************************
   // Interrupts
   // ****************************************
   // Events: flag newly set, window closed, error while tally saturated
   always_comb begin
      int_events = '0;
      int_events[`LRC_INT_ULD]    = uld_set && !unreliable_link_flag_reg;
      int_events[`LRC_INT_WINDOW] = window_end && !freeze && !clear_all;
      int_events[`LRC_INT_SAT]    = err_event && tally_max && !freeze;
   end

   // Sticky status, write one to clear, new event wins
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         int_status_reg <= `LRC_INT_RST;
      end else if (wr_en && paddr == `LRC_OFF_INT_STS) begin
         int_status_reg <= (int_status_reg & ~pwdata[2:0]) | int_events;
      end else begin
         int_status_reg <= int_status_reg | int_events;
      end
   end

   // Mask register, same layout as status
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         int_mask_reg <= `LRC_INT_RST;
      end else if (wr_en && paddr == `LRC_OFF_INT_MSK) begin
         int_mask_reg <= pwdata[2:0];
      end
   end

   // Level interrupt from any unmasked sticky bit
   assign irq = |(int_status_reg & int_mask_reg);

   // ****************************************
   // APB slave
   // ****************************************
   assign setup_ph = psel && !penable;
   assign wr_en    = psel && penable && pwrite;
   // Zero wait: data is captured in setup, so access always completes
   assign pready   = psel && penable;
   assign prdata   = prdata_reg;
   assign pslverr  = pslverr_reg && psel && penable;

   // Read mux and address decode
   always_comb begin
      rd_data = '0;
      rd_err  = 1'b0;
      unique case (paddr)
         `LRC_OFF_LINK_CTL: rd_data = '0;
         `LRC_OFF_REL_CTL:  rd_data[1:0] = reliability_control_reg;
         `LRC_OFF_REL_STS:  rd_data[`LRC_BIT_ULD] = unreliable_link_flag_reg;
         `LRC_OFF_THRESH:   rd_data = reliability_threshold_reg;
         `LRC_OFF_COUNTER:  rd_data = {window_elapsed_us, error_tally};   // RULE_11
         `LRC_OFF_INT_STS:  rd_data[2:0] = int_status_reg;
         `LRC_OFF_INT_MSK:  rd_data[2:0] = int_mask_reg;
         default:           rd_err = 1'b1;
      endcase
   end

   // Capture answer in setup so the data output comes from a flop
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata_reg  <= '0;
         pslverr_reg <= 1'b0;
      end else if (setup_ph) begin
         prdata_reg  <= pwrite ? 32'h00000000 : rd_data;
         pslverr_reg <= rd_err;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_tally_sat;
      @(posedge clk) disable iff (!arst_n)
      (tally_max && !clear_all && !window_end) |=> (error_tally == 8'hFF);
   endproperty
   a_tally_sat: assert property (p_tally_sat)   // RULE_01
      else $error("error tally left saturation");

   property p_tally_clear;
      @(posedge clk) disable iff (!arst_n)
      (retrain_pulse_reg || link_detect) |=> (error_tally == 8'h00);
   endproperty
   a_tally_clear: assert property (p_tally_clear)   // RULE_02
      else $error("error tally not cleared by retrain or detect");

   property p_en_rise_clear;
      @(posedge clk) disable iff (!arst_n)
      $rose(enable) |=> (error_tally == 8'h00 && window_elapsed_us == 24'h000000);
   endproperty
   a_en_rise_clear: assert property (p_en_rise_clear)   // RULE_03
      else $error("counters not cleared on enable rising");

   property p_tally_freeze;
      @(posedge clk) disable iff (!arst_n)
      (freeze && !clear_all) |=> (error_tally == $past(error_tally));
   endproperty
   a_tally_freeze: assert property (p_tally_freeze)   // RULE_04
      else $error("error tally moved while link unreliable");

   property p_tally_restart;
      @(posedge clk) disable iff (!arst_n)
      (window_end && !freeze && !clear_all) |=> (error_tally == 8'h00);
   endproperty
   a_tally_restart: assert property (p_tally_restart)   // RULE_05
      else $error("error tally not restarted at window end");

   property p_run_disabled;
      @(posedge clk) disable iff (!arst_n)
      (!enable && us_tick && !freeze && !clear_all && !window_end && !window_max)
      |=> (window_elapsed_us == $past(window_elapsed_us) + 24'h000001);
   endproperty
   a_run_disabled: assert property (p_run_disabled)   // RULE_06
      else $error("window counter stopped while disabled");

   property p_window_sat;
      @(posedge clk) disable iff (!arst_n)
      (window_max && !clear_all && !window_end) |=> window_max;
   endproperty
   a_window_sat: assert property (p_window_sat)   // RULE_07
      else $error("window counter wrapped");

   property p_window_clear;
      @(posedge clk) disable iff (!arst_n)
      (retrain_pulse_reg || link_detect) |=> (window_elapsed_us == 24'h000000);
   endproperty
   a_window_clear: assert property (p_window_clear)   // RULE_08
      else $error("window counter not cleared by retrain or detect");

   property p_window_freeze;
      @(posedge clk) disable iff (!arst_n)
      (freeze && !clear_all) |=> $stable(window_elapsed_us);
   endproperty
   a_window_freeze: assert property (p_window_freeze)   // RULE_09
      else $error("window counter moved while link unreliable");

   property p_window_restart;
      @(posedge clk) disable iff (!arst_n)
      (window_end && !freeze && !clear_all) |=> (window_elapsed_us == 24'h000000);
   endproperty
   a_window_restart: assert property (p_window_restart)   // RULE_10
      else $error("window counter not restarted at period");

   property p_count_read;
      @(posedge clk) disable iff (!arst_n)
      (setup_ph && !pwrite && paddr == `LRC_OFF_COUNTER)
      |=> (prdata == {$past(window_elapsed_us), $past(error_tally)});
   endproperty
   a_count_read: assert property (p_count_read)   // RULE_11
      else $error("counter register read wrong value");

   property p_uld_set;
      @(posedge clk) disable iff (!arst_n)
      uld_set |=> unreliable_link_flag_reg ##1 1'b1;
   endproperty
   a_uld_set: assert property (p_uld_set)   // RULE_12
      else $error("unreliable flag not set at threshold");

   property p_type_select;
      @(posedge clk) disable iff (!arst_n)
      (reliability_control_reg[`LRC_BIT_TYPE] == `LRC_ETYPE_BIT && link_state_error &&
       !link_bit_error && !clear_all && !window_end)
      |=> $stable(error_tally);
   endproperty
   a_type_select: assert property (p_type_select)   // RULE_13
      else $error("state error counted in bit error mode");

   property p_tick_spacing;
      @(posedge clk) disable iff (!arst_n)
      us_tick |=> !us_tick [*8];
   endproperty
   a_tick_spacing: assert property (p_tick_spacing)   // RULE_15
      else $error("microsecond ticks too close");
endmodule
`default_nettype wire

// ### link_reliability_counters_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lrc_defs.svh"
module link_reliability_counters_tb;
   // ****************************************
   // Signals
   // ****************************************
   logic        clk;                  // Core clock
   logic        arst_n;               // Async reset, active low
   logic        psel;                 // APB select
   logic        penable;              // APB access phase
   logic        pwrite;               // APB direction
   logic [15:0] paddr;                // APB address
   logic [31:0] pwdata;               // APB write data
   logic [31:0] prdata;               // APB read data
   logic        pready;               // APB ready
   logic        pslverr;              // APB error
   logic        link_bit_error;       // Bit error pulse
   logic        link_state_error;     // State error pulse
   logic        link_detect;          // Link in detect
   logic        link_retrain_request; // Retrain pulse
   logic        irq;                  // Interrupt level
   int          n_errors;             // Mismatches
   int          checks_done;          // Comparisons
   int          cyc;                  // Cycle count for timeout
   logic [31:0] rd;                   // Last read data
   logic [31:0] snap;                 // Saved counter value
   logic        err;                  // Last slave error
   typedef struct {logic [15:0] a; logic [31:0] v; logic e;} row_t;
   row_t        rows [8];             // Reset value table

   // ****************************************
   // Design
   // ****************************************
   link_reliability_counters dut (
      .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link_bit_error(link_bit_error),
      .link_state_error(link_state_error), .link_detect(link_detect),
      .link_retrain_request(link_retrain_request), .irq(irq));

   // Clock, 10 ns period
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard: well above the few thousand cycles the tests use
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors = n_errors + 1;
         tally_and_finish();
      end
   end

   // ****************************************
   // Tasks
   // ****************************************
   // Compare one value, four-state exact
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   // One APB transfer; waits for pready, bounded
   task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // No wait-state count assumed; the hang guard ends a stuck transfer
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Error pulses, one every other cycle
   task automatic pulse(input int n, input logic st);
      repeat (n) begin
         @(posedge clk);
         link_bit_error   <= ~st;
         link_state_error <= st;
         @(posedge clk);
         link_bit_error   <= 1'b0;
         link_state_error <= 1'b0;
      end
   endtask

   // Verdict and end of run
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {psel, penable, pwrite, link_bit_error, link_state_error, link_detect} = 6'h00;
      paddr = 16'h0000;
      pwdata = 32'h00000000;
      n_errors = 0;
      checks_done = 0;
      cyc = 0;
      arst_n = 1'b0;
      rows = '{'{`LRC_OFF_COUNTER, 32'h0, 1'b0}, '{`LRC_OFF_THRESH, 32'hFFFFFFFF, 1'b0},
               '{`LRC_OFF_REL_CTL, 32'h0, 1'b0}, '{`LRC_OFF_REL_STS, 32'h0, 1'b0},
               '{`LRC_OFF_INT_STS, 32'h0, 1'b0}, '{`LRC_OFF_INT_MSK, 32'h0, 1'b0},
               '{`LRC_OFF_LINK_CTL, 32'h0, 1'b0}, '{16'h0004, 32'h0, 1'b1}};
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      // Reset values and decode, one row at a time
      foreach (rows[i]) begin
         xfer(1'b0, rows[i].a, 32'h0);
         chk("reset value", rd, rows[i].v);
         chk("slave error", {31'h0, err}, {31'h0, rows[i].e});
      end
      // Counter register is read-only
      xfer(1'b1, `LRC_OFF_COUNTER, 32'hFFFFFFFF);
      xfer(1'b0, `LRC_OFF_COUNTER, 32'h0);
      chk("ro counter", rd, 32'h0);
      // Bit errors counted while disabled, state errors ignored
      pulse(5, 1'b0);
      pulse(2, 1'b1);
      xfer(1'b0, `LRC_OFF_COUNTER, 32'h0);
      chk("tally bit", {24'h0, rd[7:0]}, 32'h5);
      // Retrain clears both, pulse seen next cycle; let the window move first
      repeat (200) @(posedge clk);
      xfer(1'b1, `LRC_OFF_LINK_CTL, 32'h20);
      @(posedge clk);
      chk("retrain pulse", {31'h0, link_retrain_request}, 32'h1);
      xfer(1'b0, `LRC_OFF_COUNTER, 32'h0);
      chk("retrain clr", {31'h0, rd[31:8] <= 24'h1 && rd[7:0] == 8'h0}, 32'h1);
      // Microsecond window advances by one per 100 cycles
      repeat (1000) @(posedge clk);
      xfer(1'b0, `LRC_OFF_COUNTER, 32'h0);
      chk("window us", {31'h0, rd[31:8] >= 24'hA && rd[31:8] <= 24'hB}, 32'h1);
      // State error type counts only state errors
      xfer(1'b1, `LRC_OFF_REL_CTL, 32'h2);
      xfer(1'b1, `LRC_OFF_LINK_CTL, 32'h20);
      pulse(3, 1'b1);
      pulse(4, 1'b0);
      xfer(1'b0, `LRC_OFF_COUNTER, 32'h0);
      chk("tally state", {24'h0, rd[7:0]}, 32'h3);
      // Tally saturates; error while full raises an interrupt
      xfer(1'b1, `LRC_OFF_REL_CTL, 32'h0);
      pulse(300, 1'b0);
      xfer(1'b0, `LRC_OFF_COUNTER, 32'h0);
      chk("tally sat", {24'h0, rd[7:0]}, 32'hFF);
      chk("irq masked", {31'h0, irq}, 32'h0);
      xfer(1'b1, `LRC_OFF_INT_MSK, 32'h4);
      @(posedge clk);
      chk("irq on", {31'h0, irq}, 32'h1);
      xfer(1'b1, `LRC_OFF_INT_STS, 32'h4);
      @(posedge clk);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      // Detect level clears both counters
      @(posedge clk);
      link_detect <= 1'b1;
      repeat (3) @(posedge clk);
      link_detect <= 1'b0;
      xfer(1'b0, `LRC_OFF_COUNTER, 32'h0);
      chk("detect clr", {31'h0, rd[31:8] <= 24'h1 && rd[7:0] == 8'h0}, 32'h1);
      // Enable rise clears, threshold 3 flags and freezes
      xfer(1'b1, `LRC_OFF_THRESH, 32'hFFFFFF03);
      pulse(2, 1'b0);
      repeat (250) @(posedge clk);
      xfer(1'b1, `LRC_OFF_REL_CTL, 32'h1);
      xfer(1'b0, `LRC_OFF_COUNTER, 32'h0);
      chk("enable clr", {31'h0, rd[31:8] <= 24'h1 && rd[7:0] == 8'h0}, 32'h1);
      pulse(3, 1'b0);
      repeat (3) @(posedge clk);
      xfer(1'b0, `LRC_OFF_REL_STS, 32'h0);
      chk("flag set", rd, 32'h1);
      xfer(1'b0, `LRC_OFF_COUNTER, 32'h0);
      snap = rd;
      pulse(2, 1'b0);
      repeat (300) @(posedge clk);
      xfer(1'b0, `LRC_OFF_COUNTER, 32'h0);
      chk("frozen", rd, snap);
      // Flag survives disable; only a written one clears it
      xfer(1'b1, `LRC_OFF_REL_CTL, 32'h0);
      xfer(1'b0, `LRC_OFF_REL_STS, 32'h0);
      chk("flag sticky", rd, 32'h1);
      xfer(1'b1, `LRC_OFF_REL_STS, 32'h1);
      xfer(1'b0, `LRC_OFF_REL_STS, 32'h0);
      chk("flag w1c", rd, 32'h0);
      // Period 3: window never passes 3, tally restarts
      xfer(1'b1, `LRC_OFF_THRESH, 32'h000003FF);
      xfer(1'b1, `LRC_OFF_INT_STS, 32'h7);
      xfer(1'b1, `LRC_OFF_LINK_CTL, 32'h20);
      pulse(2, 1'b0);
      repeat (8) begin
         repeat (70) @(posedge clk);
         xfer(1'b0, `LRC_OFF_COUNTER, 32'h0);
         chk("window cap", {31'h0, rd[31:8] <= 24'h3}, 32'h1);
      end
      chk("tally restart", {24'h0, rd[7:0]}, 32'h0);
      xfer(1'b0, `LRC_OFF_INT_STS, 32'h0);
      chk("window int", {31'h0, rd[1]}, 32'h1);
      // Mid-run reset puts threshold and sticky status back to default
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      xfer(1'b0, `LRC_OFF_THRESH, 32'h0);
      chk("reset thresh", rd, 32'hFFFFFFFF);
      xfer(1'b0, `LRC_OFF_INT_STS, 32'h0);
      chk("reset int", rd, 32'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
